// file: src/dsm_ctrl.sv
/*
  Drive operating-state machine: decodes the 16-bit control word written by
  the fieldbus master and reports the 16-bit drive_state_word.
  Assumes ctrl_wr pulses for one cycle with ctrl_word valid; all inputs
  synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_ctrl #(
  parameter int MAINS_TIMEOUT = dsm_pkg::MAINS_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_word,
  input wire logic separate_ctrl_stage,
  input wire logic contactor_ctrl_en,
  input wire logic power_present,
  input wire logic fast_stop_term,
  input wire logic freewheel_term,
  input wire logic fault_detect,
  input wire logic fault_react_done,
  input wire logic warning_in,
  input wire logic target_reached_in,
  input wire logic limit_active_in,
  input wire logic stop_key_in,
  input wire logic fieldbus_ctrl_in,
  input wire logic [2:0] dir_sel,
  input wire logic [2:0] fast_stop_sel,
  input wire logic [2:0] freewheel_sel,
  input wire logic [2:0] dc_inject_sel,
  output logic [15:0] drive_state_word,
  output logic motor_power_en,
  output logic motion_halt,
  output logic reverse_dir,
  output logic dc_inject,
  output logic contactor_close,
  output logic contactor_error,
  output logic no_power_display
);
  import dsm_pkg::*;

  dsm_state_t state_q;
  dsm_state_t state_d;
  logic [15:0] cw_q;
  logic fault_rst_prev_q;
  logic from_qstop_q;
  logic tmo_expired;
  logic fault_rst_edge;
  logic fast_stop_req;
  logic freewheel_req;

  // selects the control bit named by a code; NONE and bad codes give 0
  function automatic logic sel_bit(input logic [15:0] cw, input logic [2:0] code);
    logic r;
    r = 1'b0;
    case (code)
      SEL_BIT11: r = cw[11];
      SEL_BIT12: r = cw[12];
      SEL_BIT13: r = cw[13];
      SEL_BIT14: r = cw[14];
      SEL_BIT15: r = cw[15];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : sel_bit

  // ************************************************************
  // control word capture
  // ************************************************************
  // the word stands until rewritten; edges of fault reset are taken per write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cw_q <= CW_RESET;
      fault_rst_prev_q <= 1'b0;
    end else if (ce && ctrl_wr) begin
      cw_q <= ctrl_word;
      fault_rst_prev_q <= ctrl_word[CW_FAULT_RST];
    end
  end

  assign fault_rst_edge = ctrl_wr && ctrl_word[CW_FAULT_RST] && !fault_rst_prev_q;
  assign fast_stop_req = fast_stop_term || sel_bit(cw_q, fast_stop_sel);
  assign freewheel_req = freewheel_term || sel_bit(cw_q, freewheel_sel);

  // ************************************************************
  // mains-voltage timeout in switched on
  // ************************************************************
  dsm_timeout #(
    .LIMIT(MAINS_TIMEOUT)
  ) u_tmo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .arm(separate_ctrl_stage && state_q == ST_SWITCHED && !power_present),
    .expired(tmo_expired)
  );

  // ************************************************************
  // next-state decode; faults first, then stops, then commands
  // ************************************************************
  always_comb begin
    logic sw_on;
    logic en_v;
    logic qs_n;
    logic en_op;
    sw_on = cw_q[CW_SWITCH_ON];
    en_v = cw_q[CW_EN_VOLT];
    qs_n = cw_q[CW_QSTOP_N];
    en_op = cw_q[CW_EN_OP];
    state_d = state_q;
    case (state_q)
      ST_NOT_READY: state_d = ST_SO_DIS;
      ST_SO_DIS: begin
        if (en_v && qs_n && !sw_on && !freewheel_req) state_d = ST_READY;
      end
      ST_READY: begin
        if (!en_v || freewheel_req) state_d = ST_SO_DIS;
        else if (!qs_n) state_d = ST_SO_DIS;
        else if (sw_on && en_op && !separate_ctrl_stage) state_d = ST_SWITCHED;
        else if (sw_on) state_d = ST_SWITCHED;
      end
      ST_SWITCHED: begin
        if (tmo_expired) state_d = ST_FAULT_REACT;
        else if (!en_v || freewheel_req) state_d = ST_SO_DIS;
        else if (!qs_n) state_d = ST_SO_DIS;
        else if (!sw_on) state_d = ST_READY;
        else if (en_op && !fast_stop_req && (power_present || !separate_ctrl_stage)) state_d = ST_OP_EN;
      end
      ST_OP_EN: begin
        if (!en_v || freewheel_req) state_d = ST_SO_DIS;
        else if (fast_stop_req) state_d = ST_SWITCHED;
        else if (!qs_n) state_d = ST_QSTOP;
        else if (!sw_on) state_d = ST_READY;
        else if (!en_op) state_d = ST_SWITCHED;
      end
      ST_QSTOP: begin
        if (!en_v || freewheel_req) state_d = ST_SO_DIS;
      end
      ST_FAULT_REACT: begin
        if (fault_react_done) state_d = ST_FAULT;
      end
      ST_FAULT: begin
        if (fault_rst_edge && !fault_detect) state_d = ST_SO_DIS;
      end
      default: state_d = ST_NOT_READY;
    endcase
    if (fault_detect && state_q != ST_FAULT && state_q != ST_FAULT_REACT) begin
      state_d = ST_FAULT_REACT;
    end
  end

  // ************************************************************
  // state register and fault bookkeeping
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_NOT_READY;
      from_qstop_q <= 1'b0;
      contactor_error <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_d == ST_FAULT_REACT && state_q != ST_FAULT_REACT) begin
        from_qstop_q <= (state_q == ST_QSTOP);
      end
      // error flag held until a fault reset leaves the fault state
      if (tmo_expired && state_q == ST_SWITCHED) contactor_error <= 1'b1;
      else if (state_q == ST_FAULT && state_d == ST_SO_DIS) contactor_error <= 1'b0;
    end
  end

  // ************************************************************
  // status word, registered from the next state so it matches state_q
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_state_word <= SW_RESET;
    end else if (ce) begin
      logic [15:0] s;
      s = 16'h0000; // bits 8, 12, 13 stay zero
      s[SW_QSTOP_N] = 1'b1;
      s[SW_VOLT] = power_present || !separate_ctrl_stage;
      case (state_d)
        ST_SO_DIS: begin
          s[SW_SODIS] = 1'b1;
          s[SW_QSTOP_N] = 1'b0; // must not leak into the masked test, 0040
        end
        ST_READY: s[SW_RDY] = 1'b1; // 0021 or 0031
        ST_SWITCHED: s[1:0] = 2'h3; // 0023
        ST_OP_EN: s[2:0] = 3'h7; // 0027
        ST_QSTOP: begin
          s[2:0] = 3'h7;
          s[SW_QSTOP_N] = 1'b0; // 0007
        end
        ST_FAULT_REACT: begin
          s[3:0] = 4'hF;
          // on the entry edge the origin flag is still being written, so look at the old state
          s[SW_QSTOP_N] = (state_q == ST_FAULT_REACT) ? !from_qstop_q : (state_q != ST_QSTOP);
        end
        ST_FAULT: begin
          s[SW_FAULT] = 1'b1; // 0008 or 0028
          s[SW_QSTOP_N] = from_qstop_q;
        end
        default: s[SW_QSTOP_N] = 1'b0;
      endcase
      s[SW_WARN] = warning_in;
      s[SW_REMOTE] = fieldbus_ctrl_in;
      s[SW_TARGET] = target_reached_in;
      s[SW_LIMIT] = limit_active_in;
      s[SW_STOPKEY] = stop_key_in;
      s[SW_DIR] = sel_bit(cw_q, dir_sel);
      drive_state_word <= s;
    end
  end

  // ************************************************************
  // drive function outputs
  // ************************************************************
  // halt never changes state; it only gates power and motion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      motor_power_en <= 1'b0;
      motion_halt <= 1'b0;
      reverse_dir <= 1'b0;
      dc_inject <= 1'b0;
    end else if (ce) begin
      motion_halt <= cw_q[CW_HALT] && state_d == ST_OP_EN;
      motor_power_en <= (state_d == ST_OP_EN || state_d == ST_QSTOP) && !cw_q[CW_HALT];
      reverse_dir <= sel_bit(cw_q, dir_sel);
      dc_inject <= sel_bit(cw_q, dc_inject_sel);
    end
  end

  // ************************************************************
  // mains contactor and no-power display
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contactor_close <= 1'b0;
      no_power_display <= 1'b0;
    end else if (ce) begin
      contactor_close <= contactor_ctrl_en &&
        (state_d == ST_SWITCHED || state_d == ST_OP_EN || state_d == ST_QSTOP);
      no_power_display <= separate_ctrl_stage && !power_present && state_d == ST_READY;
    end
  end
endmodule : dsm_ctrl
`default_nettype wire

// file: src/dsm_pkg.sv
/*
  Package for the drive state machine controller: control-word and status-word
  field positions, source selection codes, the state-test mask, operating states and timing constants.
  Assumes a single 10 MHz system clock; used by dsm_ctrl and dsm_timeout.
*/
// Summary of operation
// - halt interrupts motion but the drive stays in operation enabled (state 5).
// - while halt is active, motor power is removed and no torque applied.
// - a fast stop request from terminal or assigned bit goes to switched on.
// - a freewheel request from input or assigned bit goes to switch on disabled.
// - control bits 11 to 15 each selectable as a function source by code.
// - after reset bit 11 drives direction: 0 forward, 1 reverse.
// - status bits 0-7, 9, 10, 11, 14, 15 as defined; 8, 12, 13 read zero.
// - status AND 006F gives 0040, 0021, 0023, 0027, 0007, 0008 per state.
// - fault reaction sets fault plus bits 0-2; fault clears 0-2; after quick stop 0028.
// - single supply: enable operation accepted directly from ready to switch on; the code steps through switched on (state 4) for one cycle first.
// - voltage enabled reflects power stage presence: 21 absent, 31 present in state 3.
// - power absent past mains timeout in switched on raises contactor error, faults.
// - with contactor control, switch on in state 3 closes the contactor output.
// - control bits: 0 switch on, 1 enable voltage, 2 quick stop low, 3 enable, 7 reset, 8 halt.
// - commands 0006, 0007, 000F, 0000, 0002; reset on 0-to-1 edge of bit 7.
package dsm_pkg;
  // ************************************************************
  // control word fields
  // ************************************************************
  localparam int CW_SWITCH_ON = 0;
  localparam int CW_EN_VOLT = 1;
  localparam int CW_QSTOP_N = 2;
  localparam int CW_EN_OP = 3;
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT = 8;
  localparam int CW_ASSIGN_LO = 11;
  localparam int CW_ASSIGN_HI = 15;
  localparam logic [15:0] CW_RESET = 16'h0000;
  // ************************************************************
  // status word fields
  // ************************************************************
  localparam int SW_RDY = 0;
  localparam int SW_SWON = 1;
  localparam int SW_OPEN = 2;
  localparam int SW_FAULT = 3;
  localparam int SW_VOLT = 4;
  localparam int SW_QSTOP_N = 5;
  localparam int SW_SODIS = 6;
  localparam int SW_WARN = 7;
  localparam int SW_REMOTE = 9;
  localparam int SW_TARGET = 10;
  localparam int SW_LIMIT = 11;
  localparam int SW_STOPKEY = 14;
  localparam int SW_DIR = 15;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [15:0] STATE_TEST_MASK = 16'h006F;
  // ************************************************************
  // function source selection codes, one per assignable bit
  // ************************************************************
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_BIT11 = 3'h1;
  localparam logic [2:0] SEL_BIT12 = 3'h2;
  localparam logic [2:0] SEL_BIT13 = 3'h3;
  localparam logic [2:0] SEL_BIT14 = 3'h4;
  localparam logic [2:0] SEL_BIT15 = 3'h5;
  localparam logic [2:0] DIR_SEL_RESET = SEL_BIT11;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int MAINS_TIMEOUT_MS = 1000;
  localparam int MAINS_TIMEOUT_CYC = MAINS_TIMEOUT_MS * (CLK_HZ / 1000);
  // ************************************************************
  // operating states, one-hot
  // ************************************************************
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_SO_DIS = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED = 8'h08,
    ST_OP_EN = 8'h10,
    ST_QSTOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } dsm_state_t;
endpackage : dsm_pkg

// file: src/dsm_timeout.sv
/*
  Mains-voltage timeout counter: counts while armed and power absent,
  pulses expired when the limit is reached. Assumes clk, rst, ce of the top.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_timeout #(
  parameter int LIMIT = 10_000_000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic arm,
  output logic expired
);
  import dsm_pkg::*;
  logic [31:0] cnt_q;
  // ************************************************************
  // counter: restarts whenever disarmed so every wait is full length
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
      expired <= 1'b0;
    end else if (ce) begin
      expired <= 1'b0;
      if (!arm) begin
        cnt_q <= 32'h0000_0000;
      end else if (cnt_q >= 32'(LIMIT - 1)) begin
        expired <= 1'b1;
        cnt_q <= 32'h0000_0000;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
endmodule : dsm_timeout
`default_nettype wire

// file: tb/dsm_ctrl_chk.sv
/*
  Checker for dsm_ctrl: port-level relations between the control word,
  the stop inputs and the status word. Assumes ce is high wherever a response is expected.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_ctrl_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic ctrl_wr,
  input wire logic [15:0] ctrl_word,
  input wire logic contactor_ctrl_en,
  input wire logic fast_stop_term,
  input wire logic freewheel_term,
  input wire logic fault_detect,
  input wire logic [15:0] drive_state_word,
  input wire logic motor_power_en,
  input wire logic motion_halt,
  input wire logic contactor_close,
  input wire logic no_power_display
);
  import dsm_pkg::*;
  logic [15:0] st;
  logic quiet;
  // masked state and "no stop request pending", shared by several checks
  assign st = drive_state_word & STATE_TEST_MASK;
  assign quiet = ce && !fault_detect && !fast_stop_term && !freewheel_term;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ************************************************************
  // status word relations
  // ************************************************************
  chk_reserved_zero: assert property (drive_state_word[8] == 1'b0 && drive_state_word[13:12] == 2'h0)
    else $error("reserved status bits not zero");
  chk_state_legal: assert property (st inside {16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027, 16'h0007,
    16'h000F, 16'h002F, 16'h0008, 16'h0028}) else $error("masked status outside the state table");
  chk_fault_bits: assert property (drive_state_word[3] |-> drive_state_word[2:0] inside {3'h0, 3'h7})
    else $error("fault bit with partial low bits");
  chk_halt_no_power: assert property (motion_halt |-> !motor_power_en && drive_state_word[2])
    else $error("halt with motor power or outside operation");
  // ************************************************************
  // command and stop responses
  // ************************************************************
  chk_shutdown_ready: assert property (ctrl_wr && ctrl_word == 16'h0006 && st == 16'h0040 && quiet
    ##1 quiet |-> ##1 st == 16'h0021) else $error("shutdown did not reach ready in two cycles");
  chk_freewheel_exit: assert property (freewheel_term && !fault_detect && st == 16'h0027 |-> ##[1:3] st == 16'h0040)
    else $error("freewheel did not reach switch on disabled");
  chk_fast_stop: assert property (ce && fast_stop_term && !freewheel_term && !fault_detect && st == 16'h0027
    |-> ##1 st inside {16'h0023, 16'h0040}) else $error("fast stop did not leave operation enabled");
  chk_contactor_close: assert property (ctrl_wr && ctrl_word == 16'h0007 && st == 16'h0021 && contactor_ctrl_en
    && quiet |-> ##[1:3] contactor_close) else $error("contactor not closed after switch on");
  chk_contactor_state: assert property (contactor_close |-> contactor_ctrl_en && drive_state_word[1])
    else $error("contactor closed outside switched on states");
  chk_no_power_disp: assert property (no_power_display |-> st == 16'h0021 && !drive_state_word[4])
    else $error("no power display outside ready with supply absent");
endmodule : dsm_ctrl_chk
`default_nettype wire

// file: tb/dsm_master.sv
/*
  Fieldbus master model: writes control words and polls the status word.
  Assumes the drive takes ctrl_wr on the rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dsm_master (
  input wire logic clk,
  input wire logic [15:0] drive_state_word,
  output logic ctrl_wr,
  output logic [15:0] ctrl_word
);
  import dsm_pkg::*;
  initial begin
    ctrl_wr = 1'b0;
    ctrl_word = 16'h0000;
  end
  // one-cycle write; word inverted after release so stale data is never mistaken for a command
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    #1;
    ctrl_wr = 1'b1;
    ctrl_word = w;
    @(posedge clk);
    #1;
    ctrl_wr = 1'b0;
    ctrl_word = ~w;
  endtask : send
  // bounded poll; gives up after 12 cycles, and the caller goes on whether or not the state shows
  task automatic wait_state(input logic [15:0] m, output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 12 && !ok; i++) begin
      @(posedge clk);
      #1;
      ok = (drive_state_word & STATE_TEST_MASK) === m;
    end
  endtask : wait_state
endmodule : dsm_master
`default_nettype wire

// file: tb/tb.sv
/*
  Testbench for dsm_ctrl: start-up sequences, stops, assignable bits, faults.
  Assumes dsm_master as the fieldbus partner and a short mains timeout.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dsm_pkg::*;
  localparam int TMO = 20;
  logic clk, rst, ce, wr, sep, con, pwr, fst, fwt, fdet, fdone, warn, tgt, lim, skey, fbc;
  logic [2:0] dirs, fss, fws, dcs;
  logic [15:0] cw, dsw;
  logic mpe, halt, rev, dci, cclose, cerr, npd;
  int miscompares = 0;
  int num_checks = 0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dsm_master u_dsm_master (.clk(clk), .drive_state_word(dsw), .ctrl_wr(wr), .ctrl_word(cw));
  dsm_ctrl #(.MAINS_TIMEOUT(TMO)) u_dsm_ctrl (.clk(clk), .rst(rst), .ce(ce), .ctrl_wr(wr), .ctrl_word(cw),
    .separate_ctrl_stage(sep), .contactor_ctrl_en(con), .power_present(pwr), .fast_stop_term(fst),
    .freewheel_term(fwt), .fault_detect(fdet), .fault_react_done(fdone), .warning_in(warn),
    .target_reached_in(tgt), .limit_active_in(lim), .stop_key_in(skey), .fieldbus_ctrl_in(fbc),
    .dir_sel(dirs), .fast_stop_sel(fss), .freewheel_sel(fws), .dc_inject_sel(dcs), .drive_state_word(dsw),
    .motor_power_en(mpe), .motion_halt(halt), .reverse_dir(rev), .dc_inject(dci), .contactor_close(cclose),
    .contactor_error(cerr), .no_power_display(npd));
  // ************************************************************
  // shared helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic stw(input logic [15:0] m, input string nm);
    bit ok;
    u_dsm_master.wait_state(m, ok);
    chk(nm, m, dsw & STATE_TEST_MASK);
  endtask : stw
  task automatic go_op();
    u_dsm_master.send(16'h0006);
    stw(16'h0021, "ready");
    u_dsm_master.send(16'h000F);
    stw(16'h0027, "op_direct");
  endtask : go_op
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_single();
    go_op();
    chk("power_on", 16'h1, 16'(mpe));
    u_dsm_master.send(16'h010F);
    cyc(3);
    chk("halt_state", 16'h0027, dsw & STATE_TEST_MASK);
    chk("halt_power", 16'h0, {15'h0, mpe});
    chk("halt_flag", 16'h1, {15'h0, halt});
    u_dsm_master.send(16'h000F);
    cyc(3);
    chk("resume", 16'h1, {15'h0, mpe});
    chk("halt_off", 16'h0, {15'h0, halt});
    fwt = 1'b1;
    stw(16'h0040, "freewheel");
    fwt = 1'b0;
    $display("t_single done");
  endtask : t_single
  task automatic t_fast();
    go_op();
    fss = SEL_BIT12;
    u_dsm_master.send(16'h100F);
    stw(16'h0023, "fast_bit");
    fss = SEL_NONE;
    u_dsm_master.send(16'h0000);
    stw(16'h0040, "disable");
    $display("t_fast done");
  endtask : t_fast
  task automatic t_bits();
    {warn, tgt, lim, skey, fbc} = 5'h1F;
    cyc(3);
    chk("flags", 16'h4E80, dsw & 16'h7F80);
    {warn, tgt, lim, skey, fbc} = 5'h0;
    u_dsm_master.send(16'h0800);
    cyc(3);
    chk("reverse", 16'h8001, {dsw[15], 14'h0, rev});
    for (int i = 0; i < 5; i++) begin
      dcs = 3'(SEL_BIT11 + i);
      u_dsm_master.send(16'h0800 << i);
      cyc(3);
      chk("dc_inject_on", 16'h1, {15'h0, dci});
      u_dsm_master.send(16'h0000);
      cyc(3);
      chk("dc_inject_off", 16'h0, {15'h0, dci});
    end
    dcs = SEL_NONE;
    $display("t_bits done");
  endtask : t_bits
  task automatic t_sep();
    {sep, con, pwr, fdone} = 4'hD;
    u_dsm_master.send(16'h0006);
    stw(16'h0021, "sep_ready");
    chk("volt_absent", 16'h0021, dsw & 16'h007F);
    chk("no_power", 16'h1, {15'h0, npd});
    u_dsm_master.send(16'h0007);
    stw(16'h0023, "sep_switched");
    chk("contactor", 16'h1, {15'h0, cclose});
    cyc(TMO + 6);
    chk("mains_err", 16'h1, {15'h0, cerr});
    chk("mains_fault", 16'h0008, dsw & 16'h000F);
    pwr = 1'b1;
    u_dsm_master.send(16'h0000);
    u_dsm_master.send(16'h0080);
    stw(16'h0040, "reset_fault");
    chk("err_clear", 16'h0, {15'h0, cerr});
    u_dsm_master.send(16'h0006);
    stw(16'h0021, "pwr_ready");
    chk("volt_present", 16'h0031, dsw & 16'h007F);
    u_dsm_master.send(16'h0000);
    stw(16'h0040, "sep_off");
    {sep, con, fdone} = 3'h0;
    $display("t_sep done");
  endtask : t_sep
  task automatic t_fault();
    go_op();
    fdet = 1'b1;
    cyc(3);
    chk("react", 16'h000F, dsw & 16'h000F);
    fdone = 1'b1;
    cyc(3);
    chk("fault", 16'h0008, dsw & 16'h000F);
    {fdet, fdone} = 2'h0;
    u_dsm_master.send(16'h0000);
    u_dsm_master.send(16'h0080);
    stw(16'h0040, "fault_reset");
    $display("t_fault done");
  endtask : t_fault
  // quick stop and fault from it, terminal and bit stops, direction source, clock enable, mid-run reset
  task automatic t_stops();
    go_op();
    u_dsm_master.send(16'h0002);
    stw(16'h0007, "qstop");
    chk("qstop_power", 16'h1, {15'h0, mpe});
    fdet = 1'b1;
    cyc(3);
    chk("qstop_react", 16'h000F, dsw & STATE_TEST_MASK);
    fdone = 1'b1;
    cyc(3);
    chk("qstop_fault", 16'h0028, dsw & STATE_TEST_MASK);
    {fdet, fdone} = 2'h0;
    u_dsm_master.send(16'h0080);
    stw(16'h0040, "qstop_reset");
    go_op();
    fst = 1'b1;
    stw(16'h0023, "fast_term");
    chk("fast_power", 16'h0, {15'h0, mpe});
    fst = 1'b0;
    stw(16'h0027, "fast_release");
    fws = SEL_BIT13;
    u_dsm_master.send(16'h200F);
    stw(16'h0040, "freewheel_bit");
    fws = SEL_NONE;
    dirs = SEL_BIT12;
    u_dsm_master.send(16'h1000);
    cyc(3);
    chk("dir_sel", 16'h8001, {dsw[15], 14'h0, rev});
    dirs = DIR_SEL_RESET;
    u_dsm_master.send(16'h0000);
    ce = 1'b0;
    u_dsm_master.send(16'h0006);
    cyc(3);
    chk("ce_freeze", 16'h0040, dsw & STATE_TEST_MASK);
    ce = 1'b1;
    go_op();
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk("reset_word", 16'h0000, dsw);
    chk("reset_power", 16'h0, {15'h0, mpe});
    stw(16'h0040, "reset_again");
    $display("t_stops done");
  endtask : t_stops
  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {sep, con, pwr, fst, fwt, fdet, fdone, warn, tgt, lim, skey, fbc} = 12'h0;
    dirs = DIR_SEL_RESET;
    {fss, fws, dcs} = 9'h0;
    cyc(4);
    rst = 1'b0;
    stw(16'h0040, "after_reset");
    t_single();
    t_fast();
    t_bits();
    t_sep();
    t_fault();
    t_stops();
    final_report();
  end
  // generous bound: the scenarios need well under a thousand cycles
  initial begin
    #(100 * 5000);
    miscompares++;
    final_report();
  end
endmodule : tb
bind dsm_ctrl dsm_ctrl_chk u_dsm_ctrl_chk (.clk(clk), .rst(rst), .ce(ce), .ctrl_wr(ctrl_wr), .ctrl_word(ctrl_word),
  .contactor_ctrl_en(contactor_ctrl_en), .fast_stop_term(fast_stop_term), .freewheel_term(freewheel_term),
  .fault_detect(fault_detect), .drive_state_word(drive_state_word), .motor_power_en(motor_power_en),
  .motion_halt(motion_halt), .contactor_close(contactor_close), .no_power_display(no_power_display));
`default_nettype wire
